//--- verilog/adc_trig_pkg.sv
package adc_trig_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned DELAY_STEP_US = 50;
  localparam int unsigned WAIT_UNIT_US  = 20;
  localparam int unsigned DELAY_STEP_CYC_DEF =
    (DELAY_STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAIT_UNIT_CYC_DEF =
    (WAIT_UNIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned TMR_W  = 24;
  localparam int unsigned RES_W  = 11;
  localparam int unsigned CNT_W  = 9;
  localparam int unsigned ADDR_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_UPPER  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_LOWER  = 8'h0c;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [31:0]      CTRL_MASK = 32'h0000ffff;
  localparam logic [31:0]      CTRL_RST  = 32'h00000000;
  localparam logic [RES_W-1:0] UPPER_RST = 11'h7ff;
  localparam logic [RES_W-1:0] LOWER_RST = 11'h000;

  localparam int unsigned BIT_BUSY    = 0;
  localparam int unsigned BIT_LIMIT   = 1;
  localparam int unsigned BIT_ARMED   = 2;
  localparam int unsigned BIT_CNT_LSB = 8;

  localparam logic [CNT_W-1:0] ONE_SAMPLE = 9'h001;
  localparam logic [2:0]       CODE_ONE   = 3'h0;
  localparam logic [3:0]       CNT_SHIFT  = 4'h1;

  // Wait times in 20 us units, indexed by the wait code.
  localparam logic [RES_W-1:0] WAIT_UNITS [0:15] = '{
    11'h000, 11'h001, 11'h002, 11'h003, 11'h004, 11'h008, 11'h00c, 11'h010,
    11'h020, 11'h040, 11'h060, 11'h080, 11'h100, 11'h200, 11'h300, 11'h400
  };

  typedef struct packed {
    logic [15:0] rsvd;
    logic [2:0]  count_code;
    logic [3:0]  wait_code;
    logic [3:0]  delay_code;
    logic        cont;
    logic        gate;
    logic        rising;
    logic        ext;
    logic        en;
  } ctrl_s;

  typedef enum logic [2:0] {
    S_IDLE, S_ARMED, S_DELAY, S_START, S_CONVERT, S_WAIT, S_HOLD
  } seq_state_e;

endpackage

//--- verilog/interval_timer.sv
`timescale 1ns/10ps
module interval_timer
  import adc_trig_pkg::*;
(
  input  wire logic             clk_i,    // System clock.
  input  wire logic             rst_i,    // Synchronous reset, active high.
  input  wire logic             load_i,   // Start timing a new interval.
  input  wire logic [TMR_W-1:0] count_i,  // Interval length in cycles.
  output logic                  expire_o  // One-cycle pulse at interval end.
);

  logic [TMR_W-1:0] cnt_r;
  logic [TMR_W-1:0] cnt_nxt;
  logic             run_r;
  logic             run_nxt;
  logic             expire_r;
  logic             expire_nxt;

  always_comb begin
    cnt_nxt    = cnt_r;
    run_nxt    = run_r;
    expire_nxt = 1'b0;
    if (load_i) begin
      cnt_nxt = count_i;
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (cnt_r == '0) begin
        run_nxt    = 1'b0;
        expire_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r    <= '0;
      run_r    <= 1'b0;
      expire_r <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      run_r    <= run_nxt;
      expire_r <= expire_nxt;
    end
  end

  assign expire_o = expire_r;

endmodule

//--- verilog/adc_trigger_sequencer.sv
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
module adc_trigger_sequencer
  import adc_trig_pkg::*;
#(
  parameter int unsigned DELAY_STEP_CYC = DELAY_STEP_CYC_DEF,
  parameter int unsigned WAIT_UNIT_CYC  = WAIT_UNIT_CYC_DEF
)(
  input  wire logic              clk_i,           // System clock, 125 MHz.
  input  wire logic              rst_i,           // Synchronous reset, active high.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,    // Write address.
  input  wire logic              s_axi_awvalid,   // Write address valid.
  output logic                   s_axi_awready,   // Write address ready.
  input  wire logic [31:0]       s_axi_wdata,     // Write data.
  input  wire logic [3:0]        s_axi_wstrb,     // Write byte strobes.
  input  wire logic              s_axi_wvalid,    // Write data valid.
  output logic                   s_axi_wready,    // Write data ready.
  output logic [1:0]             s_axi_bresp,     // Write response.
  output logic                   s_axi_bvalid,    // Write response valid.
  input  wire logic              s_axi_bready,    // Write response ready.
  input  wire logic [ADDR_W-1:0] s_axi_araddr,    // Read address.
  input  wire logic              s_axi_arvalid,   // Read address valid.
  output logic                   s_axi_arready,   // Read address ready.
  output logic [31:0]            s_axi_rdata,     // Read data.
  output logic [1:0]             s_axi_rresp,     // Read response.
  output logic                   s_axi_rvalid,    // Read data valid.
  input  wire logic              s_axi_rready,    // Read data ready.
  input  wire logic              ext_trigger_pin, // Asynchronous trigger pin.
  input  wire logic              conv_done_i,     // Converter finished, pulse.
  input  wire logic [RES_W-1:0]  conv_result_i,   // Result valid with done.
  output logic                   conv_start_o,    // Start one conversion, pulse.
  output logic                   busy_o,          // Cycle in progress.
  output logic                   cycle_done_o,    // Cycle ended with done, pulse.
  output logic                   limit_irq_o      // Out-of-limit flag, level.
);

  // Bus and register state.
  ctrl_s             ctrl_r;
  ctrl_s             ctrl_nxt;
  logic [RES_W-1:0]  upper_r;
  logic [RES_W-1:0]  upper_nxt;
  logic [RES_W-1:0]  lower_r;
  logic [RES_W-1:0]  lower_nxt;
  logic              awready_r;
  logic              awready_nxt;
  logic              wready_r;
  logic              wready_nxt;
  logic [ADDR_W-1:0] awaddr_r;
  logic [ADDR_W-1:0] awaddr_nxt;
  logic [31:0]       wdata_r;
  logic [31:0]       wdata_nxt;
  logic [3:0]        wstrb_r;
  logic [3:0]        wstrb_nxt;
  logic              bvalid_r;
  logic              bvalid_nxt;
  logic [1:0]        bresp_r;
  logic [1:0]        bresp_nxt;
  logic              arready_r;
  logic              arready_nxt;
  logic              rvalid_r;
  logic              rvalid_nxt;
  logic [31:0]       rdata_r;
  logic [31:0]       rdata_nxt;
  logic [1:0]        rresp_r;
  logic [1:0]        rresp_nxt;
  logic              clr_limit;

  // Sequencer state.
  seq_state_e        state_r;
  seq_state_e        state_nxt;
  ctrl_s             cfg_r;
  ctrl_s             cfg_nxt;
  logic [CNT_W-1:0]  samples_r;
  logic [CNT_W-1:0]  samples_nxt;
  logic              last_r;
  logic              last_nxt;
  logic              seen_r;
  logic              seen_nxt;
  logic              busy_r;
  logic              busy_nxt;
  logic              limit_r;
  logic              limit_nxt;
  logic              done_r;
  logic              done_nxt;
  logic              start_r;
  logic              start_nxt;
  logic              en_prev_r;
  logic [2:0]        trig_sync_r;
  logic              trig_lvl_r;
  logic              trig_lvl_nxt;
  logic              trig_prev_r;

  logic              trig_edge;
  logic              trig_active;
  logic              dly_load;
  logic              dly_expire;
  logic              wait_load;
  logic              wait_expire;
  logic [TMR_W-1:0]  dly_count;
  logic [TMR_W-1:0]  wait_count;
  logic [CNT_W-1:0]  target;
  logic [CNT_W-1:0]  samples_inc;
  logic              out_of_range;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin
    ctrl_nxt    = ctrl_r;
    upper_nxt   = upper_r;
    lower_nxt   = lower_r;
    awready_nxt = awready_r;
    wready_nxt  = wready_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    clr_limit   = 1'b0;
    if (s_axi_awvalid && awready_r) begin
      awaddr_nxt  = s_axi_awaddr;
      awready_nxt = 1'b0;
    end
    if (s_axi_wvalid && wready_r) begin
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
      wready_nxt = 1'b0;
    end
    // Both halves held: commit the write once and raise the answer on the same edge.
    if (!awready_r && !wready_r && !bvalid_r) begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = RESP_OKAY;
      unique case (awaddr_r)
        ADDR_CTRL:   ctrl_nxt  = ctrl_s'(merge(ctrl_r, wdata_r, wstrb_r) & CTRL_MASK);
        ADDR_STATUS: clr_limit = wstrb_r[0] && wdata_r[BIT_LIMIT];
        ADDR_UPPER:  upper_nxt = RES_W'(merge(32'(upper_r), wdata_r, wstrb_r));
        ADDR_LOWER:  lower_nxt = RES_W'(merge(32'(lower_r), wdata_r, wstrb_r));
        default:     bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt  = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt  = 1'b1;
    end
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = RESP_OKAY;
      rdata_nxt   = '0;
      unique case (s_axi_araddr)
        ADDR_CTRL: rdata_nxt = ctrl_r;
        ADDR_STATUS: begin
          rdata_nxt[BIT_BUSY]                   = busy_r;
          rdata_nxt[BIT_LIMIT]                  = limit_r;
          rdata_nxt[BIT_ARMED]                  = (state_r == S_ARMED);
          rdata_nxt[BIT_CNT_LSB +: CNT_W]       = samples_r;
        end
        ADDR_UPPER: rdata_nxt[RES_W-1:0] = upper_r;
        ADDR_LOWER: rdata_nxt[RES_W-1:0] = lower_r;
        default:    rresp_nxt = RESP_SLVERR;
      endcase
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r    <= ctrl_s'(CTRL_RST);
      upper_r   <= UPPER_RST;
      lower_r   <= LOWER_RST;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else begin
      ctrl_r    <= ctrl_nxt;
      upper_r   <= upper_nxt;
      lower_r   <= lower_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // A glitch shorter than two cycles never reaches the edge detector.
  assign trig_lvl_nxt = (trig_sync_r[1] == trig_sync_r[2]) ? trig_sync_r[2] :
                        trig_lvl_r;
  assign trig_active  = (trig_lvl_r == cfg_r.rising);
  assign trig_edge    = (trig_lvl_r != trig_prev_r) && trig_active;

  assign dly_count   = TMR_W'(32'(cfg_r.delay_code) * DELAY_STEP_CYC);
  assign wait_count  = TMR_W'(32'(WAIT_UNITS[cfg_r.wait_code]) * WAIT_UNIT_CYC);
  assign target      = (cfg_r.count_code == CODE_ONE) ? ONE_SAMPLE :
                       CNT_W'(ONE_SAMPLE << (4'(cfg_r.count_code) + CNT_SHIFT));
  assign samples_inc = samples_r + 1'b1;
  assign out_of_range = (conv_result_i > upper_r) || (conv_result_i < lower_r);

  interval_timer u_delay (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .load_i   (dly_load),
    .count_i  (dly_count),
    .expire_o (dly_expire)
  );

  interval_timer u_wait (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .load_i   (wait_load),
    .count_i  (wait_count),
    .expire_o (wait_expire)
  );

  always_comb begin
    state_nxt   = state_r;
    cfg_nxt     = cfg_r;
    samples_nxt = samples_r;
    last_nxt    = last_r;
    seen_nxt    = seen_r;
    busy_nxt    = busy_r;
    limit_nxt   = limit_r;
    done_nxt    = 1'b0;
    start_nxt   = 1'b0;
    dly_load    = 1'b0;
    wait_load   = 1'b0;
    if (clr_limit) begin
      limit_nxt = 1'b0;
    end
    unique case (state_r)
      S_IDLE: begin
        busy_nxt = 1'b0;
        if (ctrl_r.en && !en_prev_r) begin
          cfg_nxt     = ctrl_r;
          samples_nxt = '0;
          last_nxt    = 1'b0;
          busy_nxt    = 1'b1;
          state_nxt   = ctrl_r.ext ? S_ARMED : S_START;
        end
      end
      S_ARMED: begin
        // Armed with no trigger, clearing the enable ends the cycle and clearing pin triggering starts a conversion.
        if (!ctrl_r.en) begin
          busy_nxt  = 1'b0;
          state_nxt = S_IDLE;
        end else if (trig_edge) begin
          dly_load  = 1'b1;
          state_nxt = S_DELAY;
        end else if (!ctrl_r.ext) begin
          // Pin triggering was switched off while armed, so the internal trigger takes over.
          state_nxt = S_START;
        end
      end
      S_DELAY: begin
        if (dly_expire) begin
          state_nxt = trig_active ? S_START : S_ARMED;
        end
      end
      S_START: begin
        start_nxt = 1'b1;
        state_nxt = S_CONVERT;
      end
      S_CONVERT: begin
        if (conv_done_i) begin
          samples_nxt = samples_inc;
          if (out_of_range) begin
            limit_nxt = 1'b1;
            done_nxt  = 1'b1;
            busy_nxt  = 1'b0;
            state_nxt = S_IDLE;
          end else if (last_r || (samples_inc == target && !cfg_r.cont)) begin
            done_nxt  = 1'b1;
            busy_nxt  = 1'b0;
            state_nxt = S_IDLE;
          end else if (samples_inc == target) begin
            // Live bits decide the restart so the host can leave cleanly.
            samples_nxt = '0;
            last_nxt    = !ctrl_r.cont;
            state_nxt   = ctrl_r.ext ? S_ARMED : S_START;
          end else begin
            wait_load = 1'b1;
            seen_nxt  = 1'b0;
            state_nxt = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        if (trig_edge && cfg_r.gate) begin
          seen_nxt = 1'b1;
        end
        if (wait_expire) begin
          if (cfg_r.ext && cfg_r.gate) begin
            state_nxt = ((seen_r || trig_edge) && trig_active) ? S_START : S_HOLD;
          end else begin
            state_nxt = S_START;
          end
        end
      end
      S_HOLD: begin
        if (trig_edge) begin
          state_nxt = S_START;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r     <= S_IDLE;
      cfg_r       <= ctrl_s'(CTRL_RST);
      samples_r   <= '0;
      last_r      <= 1'b0;
      seen_r      <= 1'b0;
      busy_r      <= 1'b0;
      limit_r     <= 1'b0;
      done_r      <= 1'b0;
      start_r     <= 1'b0;
      en_prev_r   <= 1'b0;
      trig_sync_r <= '0;
      trig_lvl_r  <= 1'b0;
      trig_prev_r <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cfg_r       <= cfg_nxt;
      samples_r   <= samples_nxt;
      last_r      <= last_nxt;
      seen_r      <= seen_nxt;
      busy_r      <= busy_nxt;
      limit_r     <= limit_nxt;
      done_r      <= done_nxt;
      start_r     <= start_nxt;
      en_prev_r   <= ctrl_r.en;
      trig_sync_r <= {trig_sync_r[1:0], ext_trigger_pin};
      trig_lvl_r  <= trig_lvl_nxt;
      trig_prev_r <= trig_lvl_r;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign conv_start_o  = start_r;
  assign busy_o        = busy_r;
  assign cycle_done_o  = done_r;
  assign limit_irq_o   = limit_r;

endmodule

//--- tb/converter_model.sv
`timescale 1ns/10ps
module converter_model
  import adc_trig_pkg::*;
(
  input  wire logic             clk_i,    // Clock.
  input  wire logic             rst_i,    // Reset.
  input  wire logic             start_i,  // Start pulse.
  input  wire logic [RES_W-1:0] value_i,  // Next result.
  output logic                  done_o,   // Done pulse.
  output logic [RES_W-1:0]      result_o  // Result with done.
);
  logic [2:0] cnt_r;

  // Between answers the result bus toggles, so a late sample of it sees garbage.
  always_ff @(posedge clk_i) begin
    done_o   <= (cnt_r == 3'h1);
    result_o <= (cnt_r == 3'h1) ? value_i : ~result_o;
    if (rst_i) begin
      cnt_r    <= 3'h0;
      done_o   <= 1'b0;
      result_o <= '0;
    end else if (start_i) begin
      cnt_r <= 3'h5;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end
endmodule

//--- tb/adc_trigger_sequencer_monitor.sv
`timescale 1ns/10ps
module adc_trigger_sequencer_monitor (
  input logic clk_i,          // Clock.
  input logic rst_i,          // Reset.
  input logic s_axi_awvalid,  // Bus.
  input logic s_axi_awready,  // Bus.
  input logic s_axi_wvalid,   // Bus.
  input logic s_axi_wready,   // Bus.
  input logic s_axi_bvalid,   // Bus.
  input logic s_axi_arvalid,  // Bus.
  input logic s_axi_arready,  // Bus.
  input logic s_axi_rvalid,   // Bus.
  input logic conv_start_o,   // Start.
  input logic conv_done_i,    // Done.
  input logic busy_o,         // Busy.
  input logic cycle_done_o,   // End.
  input logic limit_irq_o     // Flag.
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_start_pulse;
    conv_start_o |=> !conv_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_start_busy;
    conv_start_o |-> busy_o;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start while idle");
  property p_done_pulse;
    cycle_done_o |=> !cycle_done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_done_idle;
    cycle_done_o |-> ##[0:1] !busy_o;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("busy after done");
  property p_limit_cause;
    $rose(limit_irq_o) |-> $past(conv_done_i) || $past(conv_done_i, 2) || $past(conv_done_i, 3);
  endproperty
  a_limit_cause: assert property (p_limit_cause) else $error("flag without result");
  property p_write_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("late write response");
  property p_write_ready;
    $rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_write_ready: assert property (p_write_ready) else $error("ready during response");
  property p_read_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read_resp: assert property (p_read_resp) else $error("late read response");
endmodule

bind adc_trigger_sequencer adc_trigger_sequencer_monitor u_adc_trigger_sequencer_monitor (
  .clk_i, .rst_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .conv_start_o, .conv_done_i, .busy_o,
  .cycle_done_o, .limit_irq_o
);

//--- tb/adc_trigger_sequencer_test.sv
`timescale 1ns/10ps
module adc_trigger_sequencer_test;
  import adc_trig_pkg::*;
  localparam int DSC = 4;
  localparam int WUC = 3;
  // Wait lengths in 20 us units, kept apart from the design's own table.
  localparam int WU [16] = '{0, 1, 2, 3, 4, 8, 12, 16, 32, 64, 96, 128, 256, 512, 768, 1024};

  logic              clk_i, rst_i, ext_trigger_pin, conv_done_i;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [RES_W-1:0]  conv_result_i, value;
  logic              conv_start_o, busy_o, cycle_done_o, limit_irq_o;
  int                num_errors, comparisons, starts, dones, gap, last_gap, cycles;

  adc_trigger_sequencer #(.DELAY_STEP_CYC(DSC), .WAIT_UNIT_CYC(WUC)) u_adc_trigger_sequencer (
    .clk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_trigger_pin, .conv_done_i, .conv_result_i, .conv_start_o, .busy_o, .cycle_done_o,
    .limit_irq_o
  );
  converter_model u_converter_model (
    .clk_i, .rst_i, .start_i(conv_start_o), .value_i(value), .done_o(conv_done_i),
    .result_o(conv_result_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      end_of_test();
    end
  end

  // Counted on the falling edge so the scenarios never race the design's updates.
  always @(negedge clk_i) begin
    gap++;
    if (conv_done_i === 1'b1) gap = 0;
    if (conv_start_o === 1'b1) begin
      starts++;
      last_gap = gap;
    end
    if (cycle_done_o === 1'b1) dones++;
  end

  task automatic end_of_test;
    if (num_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("write resp", {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("read data", e, s_axi_rdata);
    chk("read resp", {30'h0, er}, {30'h0, s_axi_rresp});
    @(posedge clk_i);
  endtask

  // Flag bits b are continuous, gate, rising, external and enable, high to low.
  function automatic logic [31:0] mk(input logic [2:0] n, input logic [3:0] w,
                                     input logic [3:0] d, input logic [4:0] b);
    mk = {16'h0, n, w, d, b};
  endfunction

  // A new cycle needs the enable to fall first, so every scenario clears it.
  task automatic go(input logic [31:0] c);
    wr(ADDR_CTRL, 32'h0, 4'hf, RESP_OKAY);
    starts = 0;
    dones = 0;
    wr(ADDR_CTRL, c, 4'hf, RESP_OKAY);
  endtask

  task automatic wait_done(input int n);
    while (dones == 0 && n > 0) begin
      @(posedge clk_i);
      n--;
    end
  endtask

  task automatic t_regs;
    rd(ADDR_CTRL, CTRL_RST, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    rd(ADDR_UPPER, {21'h0, UPPER_RST}, RESP_OKAY);
    rd(ADDR_LOWER, {21'h0, LOWER_RST}, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'hffffffff, 4'hf, RESP_SLVERR);
    wr(ADDR_CTRL, 32'hfffe0000, 4'hf, RESP_OKAY);
    rd(ADDR_CTRL, 32'hfffe0000 & CTRL_MASK, RESP_OKAY);
  endtask

  task automatic t_limit;
    wr(ADDR_UPPER, 32'h100, 4'hf, RESP_OKAY);
    wr(ADDR_LOWER, 32'h010, 4'hf, RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      value <= i ? 11'h008 : 11'h101;
      go(mk(3'h2, 4'h0, 4'h0, 5'h01));
      wait_done(100);
      chk("early end", 1, starts);
      chk("limit flag", 1, limit_irq_o);
      chk("limit done", 1, dones);
      wr(ADDR_STATUS, 32'h2, 4'he, RESP_OKAY);
      chk("flag kept", 1, limit_irq_o);
      wr(ADDR_STATUS, 32'h2, 4'h1, RESP_OKAY);
      chk("flag cleared", 0, limit_irq_o);
    end
    value <= 11'h100;
  endtask

  task automatic t_counts;
    for (int c = 0; c < 8; c++) begin
      go(mk(c[2:0], 4'h0, 4'h0, 5'h01));
      wait_done(4000);
      chk("samples", (c == 0) ? 1 : 2 << c, starts);
      chk("cycle end", 1, dones);
    end
    for (int w = 0; w < 16; w++) begin
      go(mk(3'h1, w[3:0], 4'h0, 5'h01));
      wait_done(14000);
      chk("wait floor", 1, last_gap >= WU[w] * WUC);
      chk("wait ceiling", 1, last_gap <= WU[w] * WUC + 8);
    end
  endtask

  task automatic t_ext(input logic pol, input logic [3:0] dly);
    ext_trigger_pin <= pol;
    go(mk(3'h0, 4'h0, dly, {2'b00, pol, 2'b11}));
    repeat (60) @(posedge clk_i);
    chk("level only", 0, starts);
    chk("armed busy", 1, busy_o);
    rd(ADDR_STATUS, 32'h5, RESP_OKAY);
    ext_trigger_pin <= !pol;
    repeat (60) @(posedge clk_i);
    chk("wrong edge", 0, starts);
    ext_trigger_pin <= pol;
    repeat (3) @(posedge clk_i);
    ext_trigger_pin <= !pol;
    repeat (90) @(posedge clk_i);
    chk("short pulse", 0, starts);
    ext_trigger_pin <= pol;
    repeat (dly * DSC + 2) @(posedge clk_i);
    chk("delay", 0, starts);
    wait_done(60);
    chk("triggered", 1, starts);
  endtask

  task automatic t_ungated;
    ext_trigger_pin <= 1'b0;
    go(mk(3'h1, 4'h5, 4'h0, 5'h07));
    ext_trigger_pin <= 1'b1;
    repeat (20) @(posedge clk_i);
    repeat (5) begin
      ext_trigger_pin <= !ext_trigger_pin;
      repeat (6) @(posedge clk_i);
    end
    wait_done(300);
    chk("ungated samples", 4, starts);
    chk("ungated end", 1, dones);
  endtask

  task automatic t_gated;
    ext_trigger_pin <= 1'b0;
    go(mk(3'h1, 4'h1, 4'h0, 5'h0f));
    ext_trigger_pin <= 1'b1;
    repeat (60) @(posedge clk_i);
    chk("gated hold", 1, starts);
    repeat (3) begin
      ext_trigger_pin <= 1'b0;
      repeat (4) @(posedge clk_i);
      ext_trigger_pin <= 1'b1;
      repeat (40) @(posedge clk_i);
    end
    chk("gated samples", 4, starts);
  endtask

  task automatic t_cont;
    go(mk(3'h0, 4'h0, 4'h0, 5'h11));
    repeat (150) @(posedge clk_i);
    chk("restarts", 1, starts > 3);
    chk("no done", 0, dones);
    wr(ADDR_CTRL, mk(3'h0, 4'h0, 4'h0, 5'h01), 4'hf, RESP_OKAY);
    wait_done(100);
    chk("exit done", 1, dones);
    chk("exit idle", 0, busy_o);
    ext_trigger_pin <= 1'b0;
    go(mk(3'h0, 4'h0, 4'h0, 5'h17));
    repeat (3) begin
      ext_trigger_pin <= 1'b1;
      repeat (30) @(posedge clk_i);
      ext_trigger_pin <= 1'b0;
      repeat (10) @(posedge clk_i);
    end
    chk("repeat external", 3, starts);
    // Pin triggering is dropped first and continuous second, so the block must not stay armed.
    wr(ADDR_CTRL, mk(3'h0, 4'h0, 4'h0, 5'h15), 4'hf, RESP_OKAY);
    wr(ADDR_CTRL, mk(3'h0, 4'h0, 4'h0, 5'h05), 4'hf, RESP_OKAY);
    wait_done(100);
    chk("external exit done", 1, dones);
    chk("external exit idle", 0, busy_o);
    go(mk(3'h0, 4'h0, 4'h0, 5'h17));
    value <= 11'h008;
    ext_trigger_pin <= 1'b1;
    wait_done(60);
    chk("range done", 1, dones);
    chk("range flag", 1, limit_irq_o);
  endtask

  initial begin
    rst_i = 1'b1;
    ext_trigger_pin = 1'b0;
    value = 11'h080;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_limit();
    t_counts();
    t_ext(1'b1, 4'h2);
    t_ext(1'b0, 4'hf);
    t_ungated();
    t_gated();
    t_cont();
    end_of_test();
  end
endmodule
